// ---- design/stas_host.sv ----
// Host controller: replays a configuration script to the sensor, waits for settling,
// and drives the sensor's optional outside clock and sample trigger pins.
// Assumes an Avalon-MM master with waitrequest and a write-only serial link.
//
// Chosen here: register access over Avalon-MM.

module stas_host #(
	parameter int settle_base_cycles = stas_pkg::SETTLE_BASE_CYCLES,
	parameter int trig_period_min_cycles = stas_pkg::TRIG_PERIOD_MIN_CYCLES,
	parameter logic [7:0] spi_write_code = 8'h01
) (
	input wire logic clock, // System clock, 10 MHz
	input wire logic rstn, // Async reset, active low
	input wire stas_pkg::stas_avs_req_t avs_req, // Avalon request group
	output logic [31:0] avs_readdata, // Avalon read data, registered
	output logic avs_waitrequest, // Avalon stall
	output stas_pkg::stas_spi_t spi, // Serial link to sensor
	input wire logic irq_a_in, // First sensor pin, level seen
	output logic irq_a_out, // First pin drive value (outside clock)
	output logic irq_a_oe, // First pin driven by host
	input wire logic irq_b_in, // Second sensor pin, level seen
	output logic irq_b_out, // Second pin drive value (trigger)
	output logic irq_b_oe // Second pin driven by host
);

	typedef struct packed {
		stas_pkg::stas_state_t st;
		logic [3:0] idx;
		logic [4:0] len;
		logic [7:0] prev;
		logic first;
		logic pwr_seen;
		stas_pkg::stas_entry_t cur;
		logic [23:0] sh;
		logic [4:0] nbit;
		logic [7:0] div;
		logic sclk;
		logic cs_n;
		logic [23:0] settle;
		logic settled;
		logic order_err;
		logic act_warn;
		logic meas_on;
		logic outside_clock_select_on;
		logic trigger_sampling_enable;
		logic [2:0] rate;
		logic [7:0] xdiv;
		logic xclk;
		logic trig_run;
		logic [15:0] trig_period;
		logic [15:0] tcnt;
		logic trig;
		logic [15:0] trig_count;
		logic [1:0] rd_cnt;
		logic [31:0] rdata;
		logic [1:0] a_sync;
		logic [1:0] b_sync;
		logic [15:0] lvl_cnt;
		logic [15:0] gap_cnt;
		logic [7:0] xrun;
		logic [23:0] settle_seen;
	} stas_host_state_t;

	stas_host_state_t r_reg;
	stas_host_state_t r_next;
	stas_pkg::stas_entry_t mem_q;
	logic mem_we;
	logic [3:0] mem_raddr;
	logic busy;
	logic load_bad;
	logic pwr_load;
	logic bw_warn;
	logic [15:0] eff_period;

	// --------------------------------------------------------------------
	// Decoding helpers
	// --------------------------------------------------------------------

	// Word-aligned match of a bus address against a register offset
	function automatic logic csr_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction

	// Four output-rate periods in clock cycles for a rate code
	function automatic logic [23:0] settle_cycles(input logic [2:0] rate);
		logic [2:0] shift;
		shift = (rate >= stas_pkg::RATE_FASTEST) ? 3'h0 : 3'(stas_pkg::RATE_FASTEST - rate);
		return 24'(settle_base_cycles) << shift;
	endfunction

	// --------------------------------------------------------------------
	// Script store and combinational terms
	// --------------------------------------------------------------------
	assign busy = r_reg.st != stas_pkg::ST_IDLE;
	assign mem_we = avs_req.write && !busy && (avs_req.address[7:6] == stas_pkg::CSR_SCRIPT_BASE[7:6]);
	assign mem_raddr = busy ? r_reg.idx : avs_req.address[5:2];
	assign load_bad = (!r_reg.first && mem_q.addr < r_reg.prev) || r_reg.pwr_seen;
	assign pwr_load = (r_reg.st == stas_pkg::ST_LOAD) && !load_bad
		&& (mem_q.addr == stas_pkg::DEV_POWER_CONTROL);
	// rate limit floor
	// Period never shorter than the sensor's fastest triggered rate
	assign eff_period = (r_reg.trig_period < 16'(trig_period_min_cycles))
		? 16'(trig_period_min_cycles) : r_reg.trig_period;
	// bandwidth warning when trigger period exceeds one output-rate period
	assign bw_warn = r_reg.trigger_sampling_enable && r_reg.trig_run
		&& ({8'h00, eff_period} > (settle_cycles(r_reg.rate) / 24'(stas_pkg::SETTLE_ODR_PERIODS)));

	stas_script_mem u_script (
		.clock(clock),
		.rstn(rstn),
		.wr_en(mem_we),
		.wr_addr(avs_req.address[5:2]),
		.wr_data(avs_req.writedata[15:0]),
		.rd_addr(mem_raddr),
		.rd_data(mem_q)
	);

	// --------------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		// Pin synchronisers, second stage only is read
		r_next.a_sync = {r_reg.a_sync[0], irq_a_in};
		r_next.b_sync = {r_reg.b_sync[0], irq_b_in};

		// Reads answer on the third cycle so the script word can arrive
		if (avs_req.read && r_reg.rd_cnt != 2'h2) begin
			r_next.rd_cnt = r_reg.rd_cnt + 2'h1;
		end else begin
			r_next.rd_cnt = 2'h0;
		end
		if (r_reg.rd_cnt == 2'h1) begin
			r_next.rdata = 32'h0;
			if (csr_hit(avs_req.address, stas_pkg::CSR_CONTROL)) begin
				r_next.rdata[stas_pkg::CTL_TRIG_RUN_BIT] = r_reg.trig_run;
			end else if (csr_hit(avs_req.address, stas_pkg::CSR_STATUS)) begin
				r_next.rdata = {r_reg.trig_count, 7'h00, r_reg.a_sync[1],
					r_reg.b_sync[1] && !r_reg.trigger_sampling_enable, r_reg.trigger_sampling_enable, r_reg.outside_clock_select_on,
					bw_warn, r_reg.act_warn, r_reg.order_err, r_reg.settled, busy};
			end else if (csr_hit(avs_req.address, stas_pkg::CSR_LENGTH)) begin
				r_next.rdata = {27'h0, r_reg.len};
			end else if (csr_hit(avs_req.address, stas_pkg::CSR_TRIG_PERIOD)) begin
				r_next.rdata = {16'h0, r_reg.trig_period};
			end else if (avs_req.address[7:6] == stas_pkg::CSR_SCRIPT_BASE[7:6] && !busy) begin
				r_next.rdata = {16'h0, mem_q};
			end
		end

		// Register writes; length is frozen while a script runs
		if (avs_req.write) begin
			if (csr_hit(avs_req.address, stas_pkg::CSR_CONTROL)) begin
				r_next.trig_run = avs_req.writedata[stas_pkg::CTL_TRIG_RUN_BIT];
			end
			if (csr_hit(avs_req.address, stas_pkg::CSR_LENGTH) && !busy) begin
				r_next.len = (avs_req.writedata[4:0] > stas_pkg::SCRIPT_DEPTH)
					? stas_pkg::SCRIPT_DEPTH : avs_req.writedata[4:0];
			end
			if (csr_hit(avs_req.address, stas_pkg::CSR_TRIG_PERIOD)) begin
				r_next.trig_period = avs_req.writedata[15:0];
			end
		end

		// Script sequencer
		case (r_reg.st)
			stas_pkg::ST_IDLE: begin
				if (avs_req.write && csr_hit(avs_req.address, stas_pkg::CSR_CONTROL)
					&& avs_req.writedata[stas_pkg::CTL_START_BIT] && r_reg.len != 5'h0) begin
					r_next.st = stas_pkg::ST_FETCH;
					r_next.idx = 4'h0;
					r_next.first = 1'b1;
					r_next.pwr_seen = 1'b0;
					r_next.order_err = 1'b0;
					r_next.act_warn = 1'b0;
					r_next.settled = 1'b0;
					r_next.meas_on = 1'b0;
					r_next.outside_clock_select_on = 1'b0;
					r_next.trigger_sampling_enable = 1'b0;
					r_next.rate = stas_pkg::RATE_DEFAULT;
				end
			end
			stas_pkg::ST_FETCH: begin
				r_next.st = stas_pkg::ST_LOAD;
			end
			stas_pkg::ST_LOAD: begin
				// abort on descending address or entry after power control
				if (load_bad) begin
					r_next.order_err = 1'b1;
					r_next.st = stas_pkg::ST_IDLE;
				end else begin
					r_next.cur = mem_q;
					r_next.prev = mem_q.addr;
					r_next.first = 1'b0;
					if (mem_q.addr == stas_pkg::DEV_ACT_TIME && mem_q.data <= stas_pkg::ACT_TIME_MIN) begin
						r_next.act_warn = 1'b1;
					end
					// outside clock starts before the power frame goes out
					if (pwr_load) begin
						r_next.pwr_seen = 1'b1;
						r_next.outside_clock_select_on = mem_q.data[stas_pkg::PWR_OUTSIDE_CLK_BIT];
					end
					r_next.sh = {spi_write_code, mem_q.addr, mem_q.data};
					r_next.nbit = 5'h0;
					r_next.div = 8'h0;
					r_next.sclk = 1'b0;
					r_next.cs_n = 1'b0;
					r_next.st = stas_pkg::ST_SHIFT;
				end
			end
			stas_pkg::ST_SHIFT: begin
				// Mode 0: sensor samples on the rising edge, data moves on the falling
				if (r_reg.div == 8'(stas_pkg::SPI_HALF_CYCLES - 1)) begin
					r_next.div = 8'h0;
					r_next.sclk = !r_reg.sclk;
					if (r_reg.sclk) begin
						if (r_reg.nbit == 5'(stas_pkg::SPI_FRAME_BITS - 1)) begin
							r_next.cs_n = 1'b1;
							// rate code and trigger select take effect once written
							if (r_reg.cur.addr == stas_pkg::DEV_FILTER_CONTROL) begin
								r_next.trigger_sampling_enable = r_reg.cur.data[stas_pkg::FLT_TRIG_BIT];
								r_next.rate = r_reg.cur.data[stas_pkg::FLT_RATE_LSB +: 3];
							end
							// measurement on only for run field 10
							if (r_reg.cur.addr == stas_pkg::DEV_POWER_CONTROL) begin
								r_next.meas_on = r_reg.cur.data[stas_pkg::PWR_RUN_LSB +: 2]
									== stas_pkg::PWR_RUN_RUN_SELECT;
							end
							if ({1'b0, r_reg.idx} == r_reg.len - 5'h1) begin
								r_next.st = stas_pkg::ST_IDLE;
								// settle four rate periods after measurement on
								if (r_reg.cur.addr == stas_pkg::DEV_POWER_CONTROL
									&& r_reg.cur.data[stas_pkg::PWR_RUN_LSB +: 2]
									== stas_pkg::PWR_RUN_RUN_SELECT) begin
									r_next.st = stas_pkg::ST_SETTLE;
									r_next.settle = settle_cycles(r_reg.rate) - 24'h1;
								end
							end else begin
								r_next.idx = r_reg.idx + 4'h1;
								r_next.st = stas_pkg::ST_FETCH;
							end
						end else begin
							r_next.nbit = r_reg.nbit + 5'h1;
							r_next.sh = {r_reg.sh[22:0], 1'b0};
						end
					end
				end else begin
					r_next.div = r_reg.div + 8'h1;
				end
			end
			stas_pkg::ST_SETTLE: begin
				if (r_reg.settle == 24'h0) begin
					r_next.settled = 1'b1;
					r_next.st = stas_pkg::ST_IDLE;
				end else begin
					r_next.settle = r_reg.settle - 24'h1;
				end
			end
			default: begin
				r_next.st = stas_pkg::ST_IDLE;
			end
		endcase

		// outside clock divided down to at most 51.2 kHz
		if (r_reg.outside_clock_select_on) begin
			r_next.xdiv = (r_reg.xdiv == 8'(stas_pkg::OUTSIDE_CLOCK_SELECT_HALF_CYCLES - 1)) ? 8'h0 : r_reg.xdiv + 8'h1;
			r_next.xclk = (r_reg.xdiv == 8'(stas_pkg::OUTSIDE_CLOCK_SELECT_HALF_CYCLES - 1)) ? !r_reg.xclk : r_reg.xclk;
		end else begin
			r_next.xdiv = 8'h0;
			r_next.xclk = 1'b0;
		end

		// low gap is the period minus the pulse
		// a started period runs out after run is cleared, so pulses are cut short only by a script restart
		if ((r_reg.trig_run && r_reg.trigger_sampling_enable && r_reg.settled) || r_reg.tcnt != 16'h0) begin
			r_next.tcnt = (r_reg.tcnt >= eff_period - 16'h1) ? 16'h0 : r_reg.tcnt + 16'h1;
			r_next.trig = r_reg.tcnt < 16'(stas_pkg::TRIG_HIGH_CYCLES);
			if (r_reg.tcnt == 16'h0) begin
				r_next.trig_count = r_reg.trig_count + 16'h1;
			end
		end else begin
			r_next.trig = 1'b0;
		end
		// Restart releases the trigger pin at once
		if (r_next.st == stas_pkg::ST_FETCH && r_reg.st == stas_pkg::ST_IDLE) begin
			r_next.tcnt = 16'h0;
			r_next.trig = 1'b0;
		end

		// Timing observers for the pin and settle checks
		r_next.lvl_cnt = (r_next.trig != r_reg.trig) ? 16'h0
			: ((r_reg.lvl_cnt == 16'hFFFF) ? r_reg.lvl_cnt : r_reg.lvl_cnt + 16'h1);
		r_next.gap_cnt = (r_next.trig && !r_reg.trig) ? 16'h0
			: ((r_reg.gap_cnt == 16'hFFFF) ? r_reg.gap_cnt : r_reg.gap_cnt + 16'h1);
		r_next.xrun = (r_next.xclk != r_reg.xclk) ? 8'h0
			: ((r_reg.xrun == 8'hFF) ? r_reg.xrun : r_reg.xrun + 8'h1);
		r_next.settle_seen = (r_reg.st == stas_pkg::ST_SETTLE) ? r_reg.settle_seen + 24'h1 : 24'h0;
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{st: stas_pkg::ST_IDLE, cs_n: 1'b1, first: 1'b1, rate: stas_pkg::RATE_DEFAULT,
				trig_period: stas_pkg::TRIG_PERIOD_RESET, lvl_cnt: 16'hFFFF, gap_cnt: 16'hFFFF,
				xrun: 8'hFF, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from state, except waitrequest which also follows the read request
	assign avs_readdata = r_reg.rdata;
	assign avs_waitrequest = avs_req.read && r_reg.rd_cnt != 2'h2;
	assign spi = '{sclk: r_reg.sclk, mosi: r_reg.sh[23], cs_n: r_reg.cs_n};
	// first pin driven only while the outside clock is selected
	assign irq_a_out = r_reg.xclk;
	assign irq_a_oe = r_reg.outside_clock_select_on;
	// second pin becomes a host output once triggering is written
	assign irq_b_out = r_reg.trig;
	assign irq_b_oe = r_reg.trigger_sampling_enable;

	// --------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------
	sequence bad_load_s;
		r_reg.st == stas_pkg::ST_LOAD && load_bad;
	endsequence

	sequence settle_end_s;
		$rose(r_reg.settled);
	endsequence

	order_stop_a:
	assert property (@(posedge clock) disable iff (!rstn)
		bad_load_s |=> r_reg.st == stas_pkg::ST_IDLE && r_reg.order_err && spi.cs_n)
	else $error("Out-of-order script entry was not refused");

	act_time_warn_a:
	assert property (@(posedge clock) disable iff (!rstn)
		(r_reg.st == stas_pkg::ST_LOAD && !load_bad && mem_q.addr == stas_pkg::DEV_ACT_TIME
		&& mem_q.data <= stas_pkg::ACT_TIME_MIN) |=> r_reg.act_warn)
	else $error("Short activity time not flagged");

	settle_wait_a:
	assert property (@(posedge clock) disable iff (!rstn)
		settle_end_s |-> r_reg.settle_seen == settle_cycles(r_reg.rate))
	else $error("Settled raised before four rate periods");

	xclk_rate_a:
	assert property (@(posedge clock) disable iff (!rstn)
		($changed(irq_a_out) && irq_a_oe && $past(irq_a_oe))
		|-> $past(r_reg.xrun) >= 8'(stas_pkg::OUTSIDE_CLOCK_SELECT_HALF_CYCLES - 1))
	else $error("Outside clock faster than allowed");

	xclk_start_a:
	assert property (@(posedge clock) disable iff (!rstn)
		$rose(irq_a_oe) |-> $past(pwr_load))
	else $error("Outside clock started without a power control write");

	trig_drive_a:
	assert property (@(posedge clock) disable iff (!rstn)
		irq_b_out |-> irq_b_oe && r_reg.settled)
	else $error("Trigger high while pin not driven or not settled");

	trig_high_a:
	assert property (@(posedge clock) disable iff (!rstn)
		($fell(irq_b_out) && irq_b_oe) |-> $past(r_reg.lvl_cnt) >= 16'(stas_pkg::TRIG_HIGH_CYCLES - 1))
	else $error("Trigger pulse too short");

	trig_low_a:
	assert property (@(posedge clock) disable iff (!rstn)
		$rose(irq_b_out) |-> $past(r_reg.lvl_cnt) >= 16'(stas_pkg::TRIG_LOW_CYCLES - 1))
	else $error("Trigger low gap too short");

	trig_rate_a:
	assert property (@(posedge clock) disable iff (!rstn)
		$rose(irq_b_out) |-> $past(r_reg.gap_cnt) >= 16'(trig_period_min_cycles - 1))
	else $error("Trigger rate above the sensor limit");

endmodule

// ---- design/stas_pkg.sv ----
// Shared constants and carrier types for the sensor start-up and timing host.
// Assumes a 10 MHz system clock and a sensor reached over a write-only serial port.

package stas_pkg;

	// --------------------------------------------------------------------
	// Clock and timing
	// --------------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TRIG_HIGH_MIN_NS = 25000;
	localparam int TRIG_LOW_MIN_NS = 25000;
	localparam int TRIG_HIGH_CYCLES = (TRIG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIG_LOW_CYCLES = (TRIG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIG_MAX_RATE_HZ = 625;
	localparam int TRIG_PERIOD_MIN_CYCLES = (CLK_HZ + TRIG_MAX_RATE_HZ - 1) / TRIG_MAX_RATE_HZ;
	localparam int OUTSIDE_CLOCK_SELECT_MAX_HZ = 51200;
	localparam int OUTSIDE_CLOCK_SELECT_HALF_CYCLES = (CLK_HZ + 2 * OUTSIDE_CLOCK_SELECT_MAX_HZ - 1) / (2 * OUTSIDE_CLOCK_SELECT_MAX_HZ);
	localparam int SETTLE_ODR_PERIODS = 4;
	localparam int FAST_ODR_HZ = 400;
	localparam int SETTLE_BASE_CYCLES = SETTLE_ODR_PERIODS * (CLK_HZ / FAST_ODR_HZ);
	localparam int SPI_HALF_CYCLES = 5;
	localparam int SPI_FRAME_BITS = 24;

	// --------------------------------------------------------------------
	// Sensor register map and fields
	// --------------------------------------------------------------------
	localparam logic [7:0] DEV_ACT_THRESH_LOW = 8'h20;
	localparam logic [7:0] DEV_ACT_THRESH_HIGH = 8'h21;
	localparam logic [7:0] DEV_ACT_TIME = 8'h22;
	localparam logic [7:0] DEV_INACT_TIMER = 8'h25;
	localparam logic [7:0] DEV_MOTION_CONTROL = 8'h27;
	localparam logic [7:0] DEV_IRQ_MAP_B = 8'h2B;
	localparam logic [7:0] DEV_FILTER_CONTROL = 8'h2C;
	localparam logic [7:0] DEV_POWER_CONTROL = 8'h2D;
	localparam logic [7:0] ACT_TIME_MIN = 8'h01;
	localparam int PWR_RUN_LSB = 0;
	localparam logic [1:0] PWR_RUN_RUN_SELECT = 2'h2;
	localparam int PWR_WAKE_BIT = 3;
	localparam int PWR_OUTSIDE_CLK_BIT = 6;
	localparam int PWR_AUX_BIT = 7;
	localparam int FLT_TRIG_BIT = 3;
	localparam int FLT_RATE_LSB = 0;
	localparam int FLT_RANGE_LSB = 6;
	localparam logic [2:0] RATE_DEFAULT = 3'h3;
	localparam logic [2:0] RATE_FASTEST = 3'h5;

	// --------------------------------------------------------------------
	// Host register map (byte offsets, 32-bit words)
	// --------------------------------------------------------------------
	localparam logic [7:0] CSR_CONTROL = 8'h00;
	localparam logic [7:0] CSR_STATUS = 8'h04;
	localparam logic [7:0] CSR_LENGTH = 8'h08;
	localparam logic [7:0] CSR_TRIG_PERIOD = 8'h0C;
	localparam logic [7:0] CSR_SCRIPT_BASE = 8'h40;
	localparam int CTL_START_BIT = 0;
	localparam int CTL_TRIG_RUN_BIT = 1;
	localparam logic [4:0] SCRIPT_DEPTH = 5'h10;
	localparam logic [15:0] TRIG_PERIOD_RESET = 16'h3E80;

	// --------------------------------------------------------------------
	// Carrier types
	// --------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} stas_entry_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic cs_n;
	} stas_spi_t;

	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} stas_avs_req_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FETCH = 5'h02,
		ST_LOAD = 5'h04,
		ST_SHIFT = 5'h08,
		ST_SETTLE = 5'h10
	} stas_state_t;

endpackage

// ---- design/stas_script_mem.sv ----
// Sixteen-entry store for the configuration script (address and value pairs).
// Assumes one writer and one reader on the same clock; read data are registered.

module stas_script_mem (
	input wire logic clock, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic wr_en, // Write strobe
	input wire logic [3:0] wr_addr, // Write index
	input wire stas_pkg::stas_entry_t wr_data, // Entry to store
	input wire logic [3:0] rd_addr, // Read index
	output stas_pkg::stas_entry_t rd_data // Entry, one cycle after address
);

	typedef struct packed {
		logic [15:0][15:0] words;
		stas_pkg::stas_entry_t q;
	} stas_mem_state_t;

	stas_mem_state_t r_reg;
	stas_mem_state_t r_next;

	// Store on write, always register the read word
	always_comb begin
		r_next = r_reg;
		if (wr_en) begin
			r_next.words[wr_addr] = wr_data;
		end
		r_next.q = r_reg.words[rd_addr];
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rd_data = r_reg.q;

endmodule

// ---- verif/stas_sensor_model.sv ----
// Sensor stand-in: register file fed by write frames, pin drive, trigger counter.
// Assumes 24-bit frames, command byte first, bits taken on rising sclk.
module stas_sensor_model (
	input wire logic clock, // Bench clock
	input wire stas_pkg::stas_spi_t spi, // Link from host
	input wire logic pin_b, // Resolved second pin
	output logic awake, // Awake level
	output logic awake_oe // Sensor drives second pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [0:255];
	logic [23:0] sh;
	logic [2:0] sy = 3'h0;
	int nb = 0;
	int n_frames = 0;
	int n_trig = 0;
	int busy = 0;
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
		regs[8'h2C] = 8'h13;
	end
	// New frame
	always @(negedge spi.cs_n) nb = 0;
	// frames land in the register file
	always @(posedge spi.sclk) if (!spi.cs_n) begin
		sh = {sh[22:0], spi.mosi};
		nb++;
		if (nb == 24) begin
			n_frames++;
			regs[sh[15:8]] = sh[7:0];
		end
	end
	// awake drive, withdrawn once the pin is the trigger input
	assign awake_oe = regs[8'h2B][6] && !regs[8'h2C][3];
	assign awake = regs[8'h2D][1:0] == 2'h2;
	// synced edge, one set per pulse, edges ignored mid-conversion
	always @(posedge clock) begin
		sy <= {sy[1:0], pin_b};
		if (busy > 0) busy <= busy - 1;
		else if (regs[8'h2C][3] && sy[1] && !sy[2]) begin
			n_trig <= n_trig + 1;
			busy <= 100;
		end
	end
endmodule

// ---- verif/test_stas_host.sv ----
// Self-checking bench for the start-up and timing host with a sensor stand-in.
// Assumes reads answer after wait cycles and writes never stall.
module test_stas_host;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SB = 200;
	localparam int TP = 600;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	stas_pkg::stas_avs_req_t req = '0;
	stas_pkg::stas_spi_t spi;
	stas_pkg::stas_entry_t q [$];
	logic [31:0] avs_readdata, rdat, st, thr;
	logic avs_waitrequest, irq_a_in, irq_a_out, irq_a_oe, irq_b_in, irq_b_out, irq_b_oe;
	logic awake, awake_oe, b_q;
	logic a_keep = 1'b0;
	logic b_keep = 1'b0;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int hi = 0;
	int per = 0;
	int np = 0;
	int seed, t0, nf, tp_exp;
	// ----
	// Clock, design, sensor and pin keepers
	// ----
	always #50 clock = ~clock;
	stas_host #(.settle_base_cycles(SB), .trig_period_min_cycles(TP)) DUT (.clock(clock),
		.rstn(rstn), .avs_req(req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .spi(spi), .irq_a_in(irq_a_in),
		.irq_a_out(irq_a_out), .irq_a_oe(irq_a_oe), .irq_b_in(irq_b_in),
		.irq_b_out(irq_b_out), .irq_b_oe(irq_b_oe));
	stas_sensor_model M (.clock(clock), .spi(spi), .pin_b(irq_b_in), .awake(awake),
		.awake_oe(awake_oe));
	assign irq_a_in = irq_a_oe ? irq_a_out : a_keep;
	assign irq_b_in = irq_b_oe ? irq_b_out : (awake_oe ? awake : b_keep);
	// Bus keepers hold a released pin
	always @(posedge clock) begin
		a_keep <= irq_a_in;
		b_keep <= irq_b_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Pulse shape watch and the run ceiling, sampled mid-cycle where pins are settled
	always @(negedge clock) if (rstn) begin
		cyc++;
		per++;
		if (irq_b_out) hi++;
		if (irq_b_out && !b_q) begin
			if (np > 0) chk(per, tp_exp, "trigger period");
			per = 0;
			np++;
		end
		if (!irq_b_out && b_q) begin
			chk(hi, stas_pkg::TRIG_HIGH_CYCLES, "trigger width");
			hi = 0;
		end
		b_q = irq_b_out;
		if (cyc == 60000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{address: a, read: rd, write: !rd, writedata: d};
		do @(negedge clock); while (avs_waitrequest !== 1'b0);
		// Answer stands until the coming rising edge, which takes it
		rdat = avs_readdata;
		@(posedge clock);
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask
	// Load a script, start it and poll until idle
	task automatic run;
		foreach (q[i]) bus(0, stas_pkg::CSR_SCRIPT_BASE + 8'(4 * i), {16'h0, q[i]});
		bus(0, stas_pkg::CSR_LENGTH, q.size());
		bus(0, stas_pkg::CSR_CONTROL, 32'h1);
		t0 = cyc;
		do bus(1, stas_pkg::CSR_STATUS, 0); while (rdat[0] !== 1'b0);
		st = rdat;
	endtask
	function automatic int settle(input int r);
		return SB << (5 - (r > 5 ? 5 : r));
	endfunction
	// ----
	// Scenarios
	// ----
	initial begin
		seed = 32'h1f34;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		bus(1, stas_pkg::CSR_TRIG_PERIOD, 0);
		chk(rdat, 32'h3E80, "period reset");
		bus(1, 8'h30, 0);
		chk(rdat, 0, "unmapped read");
		thr = $random(seed);
		q = '{'{8'h20, thr[7:0]}, '{8'h21, 8'h00}, '{8'h22, 8'h02 + thr[15:8] % 8'hFD},
			'{8'h25, 8'h1E}, '{8'h27, 8'h3F}, '{8'h2B, 8'h40}, '{8'h2C, 8'h4B}, '{8'h2D, 8'h8A}};
		run;
		chk(cyc - t0 >= settle(3) + 8 * 240, 1, "settle wait");
		chk(st & 32'h4F, 32'h42, "status after start-up");
		foreach (q[i]) chk(M.regs[q[i].addr], q[i].data, "sensor register");
		chk(M.n_frames, 8, "frame count");
		chk(irq_b_oe, 1, "trigger pin owned");
		tp_exp = TP + ($random(seed) & 255);
		bus(0, stas_pkg::CSR_TRIG_PERIOD, tp_exp);
		bus(0, stas_pkg::CSR_CONTROL, 32'h2);
		repeat (4000) @(posedge clock);
		bus(0, stas_pkg::CSR_CONTROL, 0);
		repeat (1000) @(posedge clock);
		bus(1, stas_pkg::CSR_STATUS, 0);
		chk(rdat[31:16], np, "trigger count");
		chk(M.n_trig, np, "sample sets");
		chk(np > 4, 1, "pulses seen");
		q = '{'{8'h22, 8'h01}, '{8'h21, 8'h00}};
		nf = M.n_frames;
		run;
		chk({st[2], st[0]}, 2'b10, "order abort");
		chk(st[3], 1, "short activity time flagged");
		chk(M.n_frames - nf, 1, "frames before abort");
		q = '{'{8'h2C, 8'h03}, '{8'h2D, 8'h42}};
		run;
		chk({irq_a_oe, M.regs[8'h2D]}, {1'b1, 8'h42}, "outside clock on");
		@(posedge irq_a_out);
		t0 = cyc;
		@(negedge irq_a_out);
		chk(cyc - t0, stas_pkg::OUTSIDE_CLOCK_SELECT_HALF_CYCLES, "outside half period");
		tally_and_finish;
	end
endmodule
